// >>> ams_scheduler.sv
// adc measurement scheduler with apb register access
module ams_scheduler
  import ams_pkg::*;
#(
  parameter int SLOT_CYC = SLOT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_done,
  input wire logic [9:0] adc_data,
  output logic adc_power_on,
  output logic adc_start,
  output logic [3:0] adc_channel,
  output logic host_interrupt_n,
  output logic gp12_output,
  output logic aux1_source_on,
  output logic [5:0] aux1_current_setting,
  output logic aux2_source_on
);
  localparam int CW = $clog2(SLOT_CYC);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  ams_ctrl_s ctrl;
  logic [6:0] auto_slot_enables;
  logic [NUM_EV-1:0] event_flags;
  logic [NUM_EV-1:0] event_mask;
  logic [9:0] conv_result;
  logic [7:0] supply_result;
  logic [7:0] supply_threshold;
  logic [7:0] aux_low [3];
  logic [7:0] aux_high [3];
  logic [7:0] aux_result [3];
  logic [7:0] grp_result [3];
  logic supply_state;
  logic [1:0] sup_cnt;
  logic aux1_gate;
  ams_state_e state;
  ams_conv_s cur;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic acc;
  logic wr;
  logic [NUM_EV-1:0] ev_set;
  logic [31:0] rmux;
  logic rerr;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;

  // one wait state: answer registered in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rmux;
        pslverr <= rerr;
      end
    end
  end

  // read decode; unmapped offsets answer with an error and zero
  always_comb begin
    rmux = 32'h0000_0000;
    rerr = 1'b0;
    case (paddr)
      OFS_CTRL: rmux = ctrl;
      OFS_SLOT_EN: rmux = {25'h0, auto_slot_enables};
      OFS_EVENT: rmux = {27'h0, event_flags};
      OFS_MASK: rmux = {27'h0, event_mask};
      OFS_RES_LOW: rmux = {30'h0, conv_result[1:0]};
      OFS_RES_HIGH: rmux = {24'h0, conv_result[9:2]};
      OFS_SUPPLY: rmux = {23'h0, supply_state, supply_result};
      OFS_SUP_THR: rmux = {24'h0, supply_threshold};
      OFS_AUX_THR: rmux = {16'h0, aux_high[0], aux_low[0]};
      OFS_AUX_THR + 8'h04: rmux = {16'h0, aux_high[1], aux_low[1]};
      OFS_AUX_THR + 8'h08: rmux = {16'h0, aux_high[2], aux_low[2]};
      OFS_AUX_RES: rmux = {8'h0, aux_result[2], aux_result[1], aux_result[0]};
      OFS_GRP_RES: rmux = {8'h0, grp_result[2], grp_result[1], grp_result[0]};
      OFS_STATUS: rmux = {31'h0, state == st_conv};
      default: rerr = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // slot timing
  // ----------------------------------------------------------------
  logic [CW-1:0] slot_cyc;
  logic [6:0] slot_idx;
  logic [6:0] frame_last;
  logic slot_begin;
  assign frame_last = ctrl.economy ? 7'(FRAME_SLOTS_ECO - 1)
                                   : 7'(FRAME_SLOTS_FAST - 1);
  assign slot_begin = slot_cyc == '0;

  // economy frames run the 10 sequenced slots, then idle slots to 10 ms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cyc <= '0;
      slot_idx <= '0;
    end else if (slot_cyc == CW'(SLOT_CYC - 1)) begin
      slot_cyc <= '0;
      slot_idx <= (slot_idx >= frame_last) ? 7'h00 : slot_idx + 7'h01;
    end else begin
      slot_cyc <= slot_cyc + CW'(1);
    end
  end

  // fixed sequence of automatic sources per slot
  function automatic logic [2:0] slot_src(input logic [6:0] idx);
    case (idx)
      7'd0: slot_src = 3'd0;
      7'd1: slot_src = 3'd4;
      7'd3: slot_src = 3'd1;
      7'd4: slot_src = 3'd5;
      7'd6: slot_src = 3'd2;
      7'd7: slot_src = 3'd6;
      7'd9: slot_src = 3'd3;
      default: slot_src = SRC_NONE;
    endcase
  endfunction

  // mux channel per source: supply 0, aux 1-3, groups 8-10
  function automatic logic [3:0] src_chan(input logic [2:0] s);
    src_chan = (s > 3'd3) ? {1'b0, s} + 4'd4 : {1'b0, s};
  endfunction

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] paused;
  logic [2:0] s_now;
  logic auto_go;
  logic man_go;
  logic done_now;
  logic man_done;
  logic [NUM_SRC-1:0] auto_done;
  assign s_now = slot_src(slot_idx);
  assign paused[0] = event_flags[EV_SUPPLY];
  assign paused[6:4] = 3'b000;
  assign auto_go = slot_begin & (s_now != SRC_NONE)
                   & auto_slot_enables[s_now] & ~paused[s_now];
  // a pending request waits for a slot with no automatic work
  assign man_go = slot_begin & ~auto_go & ctrl.manual_convert_go;
  assign done_now = (state == st_conv) & adc_done;
  assign man_done = done_now & cur.manual;

  // one conversion per slot, converter powered only while converting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      cur <= '0;
      adc_start <= 1'b0;
      adc_power_on <= 1'b0;
      adc_channel <= 4'h0;
    end else begin
      adc_start <= 1'b0;
      case (state)
        st_idle: begin
          if (auto_go | man_go) begin
            cur.manual <= man_go;
            cur.src <= man_go ? SRC_NONE : s_now;
            cur.chan <= man_go ? ctrl.manual_channel : src_chan(s_now);
            adc_channel <= man_go ? ctrl.manual_channel : src_chan(s_now);
            adc_start <= 1'b1;
            adc_power_on <= 1'b1;
            state <= st_conv;
          end
        end
        st_conv: begin
          if (adc_done) begin
            adc_power_on <= 1'b0;
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // strobe per automatic source when its conversion finishes
  always_comb begin
    auto_done = '0;
    if (done_now & ~cur.manual & (cur.src != SRC_NONE)) begin
      auto_done[cur.src] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // results
  // ----------------------------------------------------------------
  // manual keeps all 10 bits; automatic keeps the top eight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_result <= 10'h000;
      supply_result <= 8'h00;
      grp_result <= '{default: 8'h00};
    end else begin
      if (man_done) begin
        conv_result <= adc_data;
      end
      if (auto_done[0]) begin
        supply_result <= adc_data[9:2];
      end
      for (int g = 0; g < 3; g++) begin
        if (auto_done[4 + g]) begin
          grp_result[g] <= adc_data[9:2];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // supply supervision
  // ----------------------------------------------------------------
  logic sup_cmp;
  logic sup_flip;
  assign sup_cmp = adc_data[9:2] >= supply_threshold;
  assign sup_flip = auto_done[0] & (sup_cmp != supply_state)
                    & (sup_cnt == 2'(SUP_DEB_READS - 1));

  // a reading that agrees with the state restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_state <= 1'b0;
      sup_cnt <= 2'b00;
    end else if (auto_done[0]) begin
      if (sup_flip) begin
        supply_state <= sup_cmp;
        sup_cnt <= 2'b00;
      end else if (sup_cmp != supply_state) begin
        sup_cnt <= sup_cnt + 2'b01;
      end else begin
        sup_cnt <= 2'b00;
      end
    end
  end

  // ----------------------------------------------------------------
  // auxiliary window checks, one copy per input
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_aux
    logic [1:0] side;
    logic [1:0] prev;
    assign side = {adc_data[9:2] > aux_high[i], adc_data[9:2] < aux_low[i]};
    // masked events neither interrupt nor hold the channel
    assign paused[1 + i] = event_flags[EV_AUX + i]
                           & ~event_mask[EV_AUX + i];
    assign ev_set[EV_AUX + i] = auto_done[1 + i] & (side != 2'b00)
      & (~ctrl.aux_debounce_select[i] | (side == prev));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prev <= 2'b00;
        aux_result[i] <= 8'h00;
      end else if (auto_done[1 + i]) begin
        prev <= side;
        aux_result[i] <= adc_data[9:2];
      end
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  assign ev_set[EV_DONE] = man_done;
  assign ev_set[EV_SUPPLY] = sup_flip;

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flags <= '0;
      host_interrupt_n <= 1'b1;
    end else begin
      event_flags <= (event_flags & ~((wr && paddr == OFS_EVENT)
                     ? pwdata[NUM_EV-1:0] : '0)) | ev_set;
      host_interrupt_n <= ~|(event_flags & ~event_mask);
    end
  end

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  // software can only raise the go bit; hardware drops it when done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      auto_slot_enables <= 7'h00;
      event_mask <= '0;
      supply_threshold <= 8'h00;
      aux_low <= '{default: 8'h00};
      aux_high <= '{default: 8'hFF};
    end else begin
      ctrl.manual_convert_go <= (ctrl.manual_convert_go & ~man_done)
        | (wr && paddr == OFS_CTRL && pwdata[1]);
      if (wr) begin
        case (paddr)
          OFS_CTRL: begin
            ctrl.economy <= pwdata[0];
            ctrl.manual_channel <= pwdata[7:4];
            ctrl.aux1_source_enable <= pwdata[8];
            ctrl.aux2_source_enable <= pwdata[9];
            ctrl.aux1_current_setting <= pwdata[15:10];
            ctrl.aux_debounce_select <= pwdata[18:16];
            ctrl.gp12_function_select <= pwdata[19];
          end
          OFS_SLOT_EN: auto_slot_enables <= pwdata[6:0];
          OFS_MASK: event_mask <= pwdata[NUM_EV-1:0];
          OFS_SUP_THR: supply_threshold <= pwdata[7:0];
          OFS_AUX_THR: {aux_high[0], aux_low[0]} <= pwdata[15:0];
          OFS_AUX_THR + 8'h04: {aux_high[1], aux_low[1]} <= pwdata[15:0];
          OFS_AUX_THR + 8'h08: {aux_high[2], aux_low[2]} <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pins: power good and current sources
  // ----------------------------------------------------------------
  logic aux1_dyn;
  assign aux1_dyn = auto_slot_enables[SRC_AUX1] & ~paused[1];

  // source off after its conversion, back on a slot early to settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux1_gate <= 1'b1;
    end else if (auto_done[1]) begin
      aux1_gate <= 1'b0;
    end else if (slot_begin && slot_idx == AUX1_SLOT - 7'h01) begin
      aux1_gate <= 1'b1;
    end
  end

  // setting outside 1..40 uA is clamped to the nearest end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp12_output <= 1'b0;
      aux1_source_on <= 1'b0;
      aux1_current_setting <= CUR_MIN;
      aux2_source_on <= 1'b0;
    end else begin
      gp12_output <= ctrl.gp12_function_select & supply_state;
      aux1_source_on <= ctrl.aux1_source_enable
                        & (aux1_gate | ~aux1_dyn);
      aux1_current_setting <=
        (ctrl.aux1_current_setting < CUR_MIN) ? CUR_MIN :
        (ctrl.aux1_current_setting > CUR_MAX) ? CUR_MAX :
        ctrl.aux1_current_setting;
      aux2_source_on <= ctrl.aux2_source_enable;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  irq_done_a: assert property (event_flags[EV_DONE] && !event_mask[EV_DONE]
    |=> !host_interrupt_n) else $error("done event not on interrupt");
  man_finish_a: assert property (man_done && !wr |=>
    !ctrl.manual_convert_go && event_flags[EV_DONE] && !adc_power_on)
    else $error("manual finish not handled");
  start_slot_a: assert property (adc_start |-> $past(slot_begin)
    && adc_power_on) else $error("conversion started mid slot");
  auto_store_a: assert property (auto_done[1] |=>
    aux_result[0] == $past(adc_data[9:2]))
    else $error("aux1 result not top eight bits");
  supply_pause_a: assert property (adc_start && !cur.manual
    && cur.src == SRC_SUPPLY |-> !event_flags[EV_SUPPLY])
    else $error("supply measured while paused");
  frame_wrap_a: assert property (slot_cyc == CW'(SLOT_CYC - 1)
    && slot_idx == frame_last |=> slot_idx == 7'h00)
    else $error("frame length wrong");
  power_good_a: assert property ((ctrl.gp12_function_select && supply_state)
    [*2] |-> gp12_output) else $error("power good not shown");
  // gate drops one edge after the done strobe, the pin one edge later
  src_off_a: assert property (auto_done[1] |=> ##1
    (!aux1_source_on || !aux1_dyn))
    else $error("aux1 source not switched off");
  sup_event_a: assert property (sup_flip |=> supply_state != $past(
    supply_state) ##0 event_flags[EV_SUPPLY])
    else $error("supply edge without event");

  man_conv_c: cover property (man_done);
  supply_ev_c: cover property (sup_flip);
  aux_ev_c: cover property (ev_set[EV_AUX]);
  eco_wrap_c: cover property (ctrl.economy && slot_idx == 7'd99
    ##1 slot_idx == 7'd0);
endmodule

// >>> ams_pkg.sv
// constants and types for the adc measurement scheduler
// Operation
// - repeat measurement frame every 1 ms fast, 10 ms in economy mode.
// - mux channels: 0 supply, 1-3 aux, 4 temperature, 8-10 groups, 5 reserved.
// - manual-convert write powers converter, one conversion, 10-bit result stored.
// - manual done powers down, self-clears go bit, sets done event.
// - interrupt driven by done event only while its mask is clear.
// - frame of 10 slots of 100 us, one measurement per slot.
// - slots with automatic measurement disabled serve manual conversions.
// - automatic results keep only the eight most significant bits.
// - slot order supply, grp1, M, aux1, grp2, M, aux2, grp3, M, aux3.
// - supply compared to threshold; state changes after three differing readings.
// - supply glitches under three readings ignored; event on both edges.
// - supply event pauses supply measurement until host clears the event.
// - gp12 output shows debounced supply state when selected.
// - supply measured automatically only while its auto enable is set.
// - aux reading below low or above high sets the window event.
// - unmasked aux event pauses channel; mask stops interrupt and pausing.
// - aux debounce needs two consecutive readings past the same threshold.
// - aux1 auto measurement only while its auto enable is set.
// - aux1 current source 1 to 40 uA, enabled by source enable bit.
// - aux1 source off after auto conversion, on one slot before next.
// - aux2, aux3 behave like aux1; aux2 source always static.
package ams_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int SLOT_US = 100;
  localparam int SLOT_CYCLES = SLOT_US * CLK_MHZ;
  localparam int FRAME_MS_FAST = 1;
  localparam int FRAME_MS_ECO = 10;
  localparam int FRAME_SLOTS_FAST = FRAME_MS_FAST * 1000 / SLOT_US;
  localparam int FRAME_SLOTS_ECO = FRAME_MS_ECO * 1000 / SLOT_US;
  localparam int SEQ_SLOTS = 10;
  localparam int SUP_DEB_READS = 3;
  localparam logic [5:0] CUR_MIN = 6'h01;
  localparam logic [5:0] CUR_MAX = 6'h28;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLOT_EN = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_RES_LOW = 8'h10;
  localparam logic [7:0] OFS_RES_HIGH = 8'h14;
  localparam logic [7:0] OFS_SUPPLY = 8'h18;
  localparam logic [7:0] OFS_SUP_THR = 8'h1C;
  localparam logic [7:0] OFS_AUX_THR = 8'h20;
  localparam logic [7:0] OFS_AUX_RES = 8'h2C;
  localparam logic [7:0] OFS_GRP_RES = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  // ----------------------------------------------------------------
  // fields and sources
  // ----------------------------------------------------------------
  localparam int EV_DONE = 0;
  localparam int EV_SUPPLY = 1;
  localparam int EV_AUX = 2;
  localparam int NUM_EV = 5;
  localparam int NUM_SRC = 7;
  localparam logic [2:0] SRC_SUPPLY = 3'h0;
  localparam logic [2:0] SRC_AUX1 = 3'h1;
  localparam logic [2:0] SRC_NONE = 3'h7;
  localparam logic [6:0] AUX1_SLOT = 7'h03;
  localparam logic [3:0] CH_RESERVED = 4'h5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0400;

  typedef enum {st_idle, st_conv} ams_state_e;

  typedef struct packed {
    logic [11:0] unused;
    logic gp12_function_select;
    logic [2:0] aux_debounce_select;
    logic [5:0] aux1_current_setting;
    logic aux2_source_enable;
    logic aux1_source_enable;
    logic [3:0] manual_channel;
    logic [1:0] spare;
    logic manual_convert_go;
    logic economy;
  } ams_ctrl_s;

  typedef struct packed {
    logic manual;
    logic [2:0] src;
    logic [3:0] chan;
  } ams_conv_s;
endpackage

// >>> ams_adc_model.sv
// converter model: answers each start pulse with one done pulse
module ams_adc_model
  import ams_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic adc_start,
  input wire logic [9:0] sample,
  input wire logic [3:0] latency,
  output logic adc_done,
  output logic [9:0] adc_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // conversion timer
  // ----------------------------------------------------------------
  logic [3:0] count;
  logic busy;

  // latency is set by the bench so prompt and slow answers both occur
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      count <= 4'h0;
      adc_done <= 1'b0;
    end else begin
      adc_done <= 1'b0;
      if (adc_start) begin
        busy <= 1'b1;
        count <= latency;
      end else if (busy && count == 4'h0) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
      end else if (busy) begin
        count <= count - 4'h1;
      end
    end
  end

  // data is only good with done; the inverse elsewhere exposes late sampling
  assign adc_data = adc_done ? sample : ~sample;
endmodule

// >>> ams_scheduler_bench.sv
// self-checking bench for the adc measurement scheduler
module ams_scheduler_bench;
  import ams_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, adc_done, adc_power_on, adc_start;
  logic [9:0] adc_data;
  logic [9:0] sample = 10'h000;
  logic [3:0] latency = 4'h2;
  logic [3:0] adc_channel;
  logic host_interrupt_n, gp12_output, aux1_source_on, aux2_source_on;
  logic [5:0] aux1_current_setting;
  int failures = 0;
  int samples_checked = 0;
  int sup_reads = 0;
  int aux_reads = 0;
  int n0;
  int cyc;

  ams_scheduler #(.SLOT_CYC(20)) i_ams_scheduler (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_done(adc_done), .adc_data(adc_data),
    .adc_power_on(adc_power_on), .adc_start(adc_start),
    .adc_channel(adc_channel), .host_interrupt_n(host_interrupt_n),
    .gp12_output(gp12_output), .aux1_source_on(aux1_source_on),
    .aux1_current_setting(aux1_current_setting),
    .aux2_source_on(aux2_source_on));

  ams_adc_model i_ams_adc_model (.pclk(pclk), .presetn(presetn),
    .adc_start(adc_start), .sample(sample), .latency(latency),
    .adc_done(adc_done), .adc_data(adc_data));

  // 125 MHz clock
  always #4 pclk = ~pclk;

  // count finished readings per channel to prove debounce depths
  always @(posedge pclk) begin
    if (adc_done === 1'b1 && adc_channel === 4'h0) sup_reads++;
    if (adc_done === 1'b1 && adc_channel === 4'h1) aux_reads++;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check({31'h0, pready}, 32'h0000_0001);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] msk);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r & msk, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  // bounded wait for the interrupt line to go active
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    // the line lags a clear by two edges; let a stale low pass first
    repeat (2) @(posedge pclk);
    while (host_interrupt_n !== 1'b0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, host_interrupt_n}, 32'h0000_0000);
  endtask

  task automatic results();
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // whole run is about 7600 cycles; the watchdog allows far more
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    results();
  end

  initial begin
    logic [31:0] r;
    logic e;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, CTRL_RESET, 32'hFFFF_FFFF);
    rd(OFS_AUX_THR, 32'h0000_FF00, 32'h0000_FFFF);
    apb(1'b0, 8'h40, 32'h0000_0000, r, e);
    check({31'h0, e}, 32'h0000_0001);
    check(r, 32'h0000_0000);
    // manual conversion on the temperature channel, all slots free
    sample <= 10'h2D6;
    wr(OFS_CTRL, 32'h0000_0442);
    wait_irq(400);
    check({28'h0, adc_channel}, 32'h0000_0004);
    check({31'h0, adc_power_on}, 32'h0000_0000);
    rd(OFS_EVENT, 32'h0000_0001, 32'h0000_001F);
    rd(OFS_CTRL, 32'h0000_0000, 32'h0000_0002);
    rd(OFS_RES_LOW, 32'h0000_0002, 32'h0000_0003);
    rd(OFS_RES_HIGH, 32'h0000_00B5, 32'h0000_00FF);
    wr(OFS_MASK, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    check({31'h0, host_interrupt_n}, 32'h0000_0001);
    wr(OFS_EVENT, 32'h0000_0001);
    wr(OFS_MASK, 32'h0000_0000);
    // supply supervision with slow converter answers
    latency <= 4'h9;
    sample <= 10'h3F4;
    wr(OFS_SUP_THR, 32'h0000_0080);
    wr(OFS_CTRL, 32'h0008_0400);
    wr(OFS_SLOT_EN, 32'h0000_0001);
    wait_irq(1000);
    check(sup_reads, 3);
    rd(OFS_SUPPLY, 32'h0000_01FD, 32'h0000_01FF);
    check({31'h0, gp12_output}, 32'h0000_0001);
    sample <= 10'h040;
    repeat (800) @(posedge pclk);
    check(sup_reads, 3);
    rd(OFS_SUPPLY, 32'h0000_01FD, 32'h0000_01FF);
    wr(OFS_EVENT, 32'h0000_0002);
    wait_irq(1000);
    check(sup_reads, 6);
    rd(OFS_SUPPLY, 32'h0000_0010, 32'h0000_01FF);
    check({31'h0, gp12_output}, 32'h0000_0000);
    wr(OFS_SLOT_EN, 32'h0000_0000);
    wr(OFS_EVENT, 32'h0000_0002);
    n0 = sup_reads;
    repeat (400) @(posedge pclk);
    check(sup_reads, n0);
    // auxiliary window with debounce, then masked
    sample <= 10'h3FC;
    wr(OFS_AUX_THR, 32'h0000_7010);
    wr(OFS_CTRL, 32'h0001_0400);
    wr(OFS_SLOT_EN, 32'h0000_0002);
    wait_irq(1000);
    check(aux_reads, 2);
    rd(OFS_AUX_RES, 32'h0000_00FF, 32'h0000_00FF);
    rd(OFS_EVENT, 32'h0000_0004, 32'h0000_001F);
    wr(OFS_MASK, 32'h0000_0004);
    wr(OFS_EVENT, 32'h0000_0004);
    n0 = aux_reads;
    repeat (600) @(posedge pclk);
    check({31'h0, host_interrupt_n}, 32'h0000_0001);
    check(aux_reads > n0 + 1, 1);
    // dynamic aux1 source: off after its conversion, on before the next
    wr(OFS_CTRL, 32'h0001_0500);
    n0 = aux_reads;
    while (aux_reads == n0) @(posedge pclk);
    repeat (3) @(posedge pclk);
    check({31'h0, aux1_source_on}, 32'h0000_0000);
    while (adc_start !== 1'b1) @(posedge pclk);
    check({31'h0, aux1_source_on}, 32'h0000_0001);
    // economy rate: supply readings one long frame apart
    wr(OFS_SLOT_EN, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0401);
    wr(OFS_SLOT_EN, 32'h0000_0001);
    n0 = sup_reads;
    while (sup_reads == n0) @(posedge pclk);
    n0 = sup_reads;
    cyc = 0;
    while (sup_reads == n0) begin
      @(posedge pclk);
      cyc++;
    end
    check(cyc, FRAME_SLOTS_ECO * 20);
    // current setting clamp and static second source
    wr(OFS_SLOT_EN, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_FF00);
    repeat (2) @(posedge pclk);
    check({26'h0, aux1_current_setting}, 32'h0000_0028);
    check({31'h0, aux2_source_on}, 32'h0000_0001);
    check({31'h0, aux1_source_on}, 32'h0000_0001);
    results();
  end
endmodule
